// >>> src/smiu_core.sv
// Special move instruction unit: flag load, status store, line copy and
// multiple register move, with its own register file on classic Wishbone.
// Assumes the core supplies decoded effective addresses and a memory bus.
//
// Summary of operation
// RQ1 - Flag load source must be a data mode; address register direct illegal.
// RQ2 - Flag load always fetches a word operand.
// RQ3 - Source bits 4..0 go to X,N,Z,V,C; upper status byte kept.
// RQ4 - Status store writes the whole word, unimplemented bits zero, flags kept.
// RQ5 - Status store destination must be data alterable.
// RQ6 - Status store to memory reads the destination before writing it.
// RQ7 - Line copy moves one aligned 16-byte line, low address bits ignored.
// RQ8 - Burst read into a holding buffer, then burst write, each from its long word.
// RQ9 - Postincrement address registers of line copy grow by 16 at the end.
// RQ10 - Postincrement line format: source reg in bits 2-0, destination in 14-12.
// RQ11 - Absolute line format: opmode, register, then 32-bit address high first.
// RQ12 - Opmode picks pairing: 00 pi-to-abs, 01 abs-to-pi, 10 ind-to-abs, 11 abs-to-ind.
// RQ13 - Multiple move transfers each masked register, word or long size.
// RQ14 - Word loads are sign-extended to 32 bits.
// RQ15 - Multiple move memory operand: control, predecrement or postincrement only.
// RQ16 - Control mode starts at the address, steps up by 2 or 4, D0..A7.
// RQ17 - Predecrement is store only, starts at register minus length, steps down.
// RQ18 - Predecrement stores A7..A0 then D7..D0; register ends at last stored address.
// RQ19 - Stored addressing register is initial minus size, or initial on legacy setting.
// RQ20 - Postincrement is load only, starts at register, steps up, control order.
// RQ21 - Postincrement register ends at last address plus length, overriding loaded value.
// RQ22 - Direction bit 0 stores, 1 loads; size bit 0 word, 1 long.
// RQ23 - Mask bit 0 is the first register moved; reversed for predecrement.
// RQ24 - Disallowed modes raise the illegal instruction pulse and move nothing.
`timescale 1ns/1ps
module smiu_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic issue_valid_i,
  input wire smiu_pkg::smiu_issue_s issue_i,
  output logic issue_ready_o,
  output logic illegal_o,
  output logic done_o,
  output logic mem_valid_o,
  output smiu_pkg::smiu_mem_s mem_req_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import smiu_pkg::*;

  // Legality of an effective address against allowed mode sets
  function automatic logic ea_legal(input logic [2:0] mode, input logic [2:0] rn,
                                    input logic [7:0] modes, input logic [7:0] abs);
    ea_legal = (mode == MODE_EXT) ? abs[rn] : modes[mode];
  endfunction

  // Byte-lane merge for Wishbone writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      lane_merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  logic [31:0] rf [16];
  logic [15:0] sr;
  logic legacy_predec;
  logic illegal_seen;
  smiu_state_e st;
  logic [31:0] addr;
  logic [31:0] daddr;
  logic [31:0] lbuf [4];
  logic [1:0] beat;
  logic [3:0] cnt;
  logic [15:0] mask;
  logic mm_load;
  logic mm_long;
  logic mm_predec;
  logic mm_postinc;
  logic [2:0] areg;
  logic [2:0] sreg;
  logic inc_src;
  logic inc_dst;
  logic [2:0] dreg;
  // Instruction field decode
  wire logic [15:0] op = issue_i.opword;
  wire logic [2:0] mode = op[5:3];
  wire logic [2:0] rn = op[2:0];
  wire logic is_flag = op[15:6] == OP_FLAG_LOAD;
  wire logic is_sst = op[15:6] == OP_STATUS_STORE;
  wire logic is_lpi = op[15:3] == OP_LINE_PI; // RQ10
  wire logic is_labs = op[15:5] == OP_LINE_ABS; // RQ11
  wire logic is_mm = op[15:11] == OP_MM_HI && op[9:7] == OP_MM_MID;
  wire logic op_load = op[10]; // RQ22
  wire logic op_long = op[6]; // RQ22
  wire logic [31:0] abs_addr = {issue_i.ext1, issue_i.ext2}; // RQ11
  wire logic [31:0] an_val = rf[{1'b1, rn}];

  // Legality per instruction; anything else from this opcode group is refused
  wire logic flag_ok = ea_legal(mode, rn, EA_DATA_MODES, EA_DATA_ABS); // RQ1
  wire logic sst_ok = ea_legal(mode, rn, EA_DALT_MODES, EA_DALT_ABS); // RQ5
  wire logic lpi_ok = (issue_i.ext1 & LINE_EXT_MASK) == LINE_EXT_VAL; // RQ10
  wire logic mm_ok = op_load ? ea_legal(mode, rn, EA_MMLD_MODES, EA_MMLD_ABS) // RQ20
                             : ea_legal(mode, rn, EA_MMST_MODES, EA_MMST_ABS); // RQ17 RQ15
  wire logic legal = (is_flag && flag_ok) || (is_sst && sst_ok) || (is_lpi && lpi_ok)
                     || is_labs || (is_mm && mm_ok);
  wire logic take = issue_valid_i && st == ST_IDLE;
  wire logic bad = take && !legal; // RQ24
  wire logic go = take && legal;

  // Multiple move step values
  wire logic [31:0] mm_len = mm_long ? LEN_LONG : LEN_WORD; // RQ13
  wire logic [31:0] op_len = op_long ? LEN_LONG : LEN_WORD;
  wire logic [3:0] mm_reg = mm_predec ? ~cnt : cnt; // RQ23
  wire logic [31:0] mm_src = rf[mm_reg];
  wire logic mm_self = mm_predec && mm_reg == {1'b1, areg};
  // Legacy setting stores the undecremented register value
  wire logic [31:0] mm_store = (mm_self && !legacy_predec) ? mm_src - mm_len : mm_src; // RQ19
  wire logic [31:0] mm_ld = mm_long ? mem_rdata_i
                                    : {{16{mem_rdata_i[15]}}, mem_rdata_i[15:0]}; // RQ14
  wire logic [15:0] sr_img = sr & SR_IMPL_MASK; // RQ4
  wire logic [31:0] sr_merged = lane_merge({16'h0000, sr}, wb_dat_i, wb_sel_i);

  // Memory request, built from held state so it stays steady until ack
  always_comb begin
    mem_req_o = '0;
    mem_valid_o = 1'b0;
    case (st)
      ST_FLAG: begin
        mem_valid_o = 1'b1;
        mem_req_o.addr = addr;
        mem_req_o.word = 1'b1; // RQ2
      end
      ST_SRRD: begin
        mem_valid_o = 1'b1;
        mem_req_o.addr = addr;
        mem_req_o.word = 1'b1; // RQ6
      end
      ST_SRWR: begin
        mem_valid_o = 1'b1;
        mem_req_o.addr = addr;
        mem_req_o.word = 1'b1;
        mem_req_o.we = 1'b1;
        mem_req_o.wdata = {16'h0000, sr_img}; // RQ4
      end
      ST_LRD: begin
        mem_valid_o = 1'b1;
        mem_req_o.addr = {addr[31:4], beat, 2'b00}; // RQ7 RQ8
        mem_req_o.burst = 1'b1;
      end
      ST_LWR: begin
        mem_valid_o = 1'b1;
        mem_req_o.addr = {daddr[31:4], beat, 2'b00}; // RQ7 RQ8
        mem_req_o.burst = 1'b1;
        mem_req_o.we = 1'b1;
        mem_req_o.wdata = lbuf[beat];
      end
      ST_MM: begin
        mem_valid_o = mask[cnt]; // RQ13
        mem_req_o.addr = addr;
        mem_req_o.word = !mm_long;
        mem_req_o.we = !mm_load;
        mem_req_o.wdata = mm_long ? mm_store : {16'h0000, mm_store[15:0]};
      end
      default: begin
        mem_valid_o = 1'b0;
      end
    endcase
  end

  assign issue_ready_o = st == ST_IDLE;
  wire logic acked = mem_valid_o && mem_ack_i;
  wire logic [1:0] next_beat = beat + 2'b01;
  wire logic line_last = next_beat == addr[3:2];
  wire logic dst_last = next_beat == daddr[3:2];

  // Wishbone slave decode: one-cycle registered ack, unmapped reads zero
  wire logic [4:0] wb_idx = wb_adr_i[6:2];
  wire logic wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic wb_wr = wb_hit && wb_we_i;
  wire logic wb_in_rf = wb_adr_i[31:6] == '0;
  wire logic wb_hi = wb_adr_i[31:7] == '0;
  wire logic [31:0] wb_rd = wb_in_rf ? rf[wb_idx[3:0]]
                          : (wb_hi && wb_idx == IDX_SR) ? {16'h0000, sr}
                          : (wb_hi && wb_idx == IDX_CTRL) ? {31'h00000000, legacy_predec}
                          : (wb_hi && wb_idx == IDX_STAT)
                            ? {30'h00000000, illegal_seen, st != ST_IDLE} : 32'h00000000;
  wire logic stat_clr = wb_wr && wb_hi && wb_idx == IDX_STAT && wb_sel_i[0] && wb_dat_i[1];

  // Bus slave registers and software-visible flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      legacy_predec <= CTRL_RESET;
      illegal_seen <= 1'b0;
      illegal_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= wb_hit ? wb_rd : 32'h00000000;
      if (wb_wr && wb_hi && wb_idx == IDX_CTRL && wb_sel_i[0]) begin
        legacy_predec <= wb_dat_i[0];
      end
      // A new refusal in the clearing cycle keeps the flag set
      illegal_seen <= bad || (illegal_seen && !stat_clr);
      illegal_o <= bad; // RQ24
    end
  end

  // Sequencer, register file and status register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= ST_IDLE;
      sr <= SR_RESET;
      done_o <= 1'b0;
      addr <= 32'h00000000;
      daddr <= 32'h00000000;
      beat <= 2'b00;
      cnt <= 4'h0;
      mask <= 16'h0000;
      mm_load <= 1'b0;
      mm_long <= 1'b0;
      mm_predec <= 1'b0;
      mm_postinc <= 1'b0;
      areg <= 3'h0;
      sreg <= 3'h0;
      dreg <= 3'h0;
      inc_src <= 1'b0;
      inc_dst <= 1'b0;
      for (int i = 0; i < 16; i++) begin
        rf[i] <= 32'h00000000;
      end
      for (int i = 0; i < 4; i++) begin
        lbuf[i] <= 32'h00000000;
      end
    end else begin
      done_o <= 1'b0;
      // Register file and status register writes land only while idle, so a transfer sees stable registers
      if (wb_wr && st == ST_IDLE && !take) begin
        if (wb_in_rf) begin
          rf[wb_idx[3:0]] <= lane_merge(rf[wb_idx[3:0]], wb_dat_i, wb_sel_i);
        end else if (wb_hi && wb_idx == IDX_SR) begin
          sr <= sr_merged[15:0] & SR_IMPL_MASK;
        end
      end
      case (st)
        ST_IDLE: begin
          if (go) begin
            addr <= issue_i.ea_addr;
            areg <= rn;
            if (is_flag) begin
              if (mode == MODE_DREG) begin
                sr[4:0] <= rf[{1'b0, rn}][4:0]; // RQ3
                done_o <= 1'b1;
              end else if (mode == MODE_EXT && rn == REG_IMM) begin
                sr[4:0] <= issue_i.ext1[4:0]; // RQ3
                done_o <= 1'b1;
              end else begin
                st <= ST_FLAG; // RQ2
              end
            end else if (is_sst) begin
              if (mode == MODE_DREG) begin
                rf[{1'b0, rn}][15:0] <= sr_img; // RQ4
                done_o <= 1'b1;
              end else begin
                st <= ST_SRRD; // RQ6
              end
            end else if (is_lpi || is_labs) begin
              // Pairing from the format and opmode
              sreg <= rn;
              dreg <= is_lpi ? issue_i.ext1[14:12] : rn; // RQ10
              inc_src <= is_lpi || (is_labs && op[4:3] == 2'b00); // RQ12
              inc_dst <= is_lpi || (is_labs && op[4:3] == 2'b01); // RQ12
              addr <= (is_lpi || !op[3]) ? an_val : abs_addr; // RQ12
              daddr <= is_lpi ? rf[{1'b1, issue_i.ext1[14:12]}]
                       : (op[3] ? an_val : abs_addr); // RQ12
              beat <= (is_lpi || !op[3]) ? an_val[3:2] : abs_addr[3:2]; // RQ8
              st <= ST_LRD;
            end else begin
              mask <= issue_i.ext1;
              cnt <= 4'h0;
              mm_load <= op_load;
              mm_long <= op_long;
              mm_predec <= mode == MODE_PREDEC;
              mm_postinc <= mode == MODE_POSTINC;
              if (mode == MODE_PREDEC) begin
                addr <= an_val - op_len; // RQ17
              end else if (mode == MODE_POSTINC) begin
                addr <= an_val; // RQ20
              end
              st <= ST_MM;
            end
          end
        end
        ST_FLAG: begin
          if (acked) begin
            sr[4:0] <= mem_rdata_i[4:0]; // RQ3
            st <= ST_FIN;
          end
        end
        ST_SRRD: begin
          if (acked) begin
            st <= ST_SRWR; // RQ6
          end
        end
        ST_SRWR: begin
          if (acked) begin
            st <= ST_FIN;
          end
        end
        ST_LRD: begin
          if (acked) begin
            lbuf[beat] <= mem_rdata_i; // RQ8
            beat <= line_last ? daddr[3:2] : next_beat;
            if (line_last) begin
              st <= ST_LWR;
            end
          end
        end
        ST_LWR: begin
          if (acked) begin
            beat <= next_beat;
            if (dst_last) begin
              st <= ST_FIN;
            end
          end
        end
        ST_MM: begin
          if (!mask[cnt] || acked) begin
            if (mask[cnt]) begin
              // Predecrement steps down, the other modes step up
              addr <= mm_predec ? addr - mm_len : addr + mm_len; // RQ16 RQ17 RQ20
              if (mm_load) begin
                rf[mm_reg] <= mm_ld; // RQ14
              end
            end
            cnt <= cnt + 4'h1;
            if (cnt == 4'hF) begin
              st <= ST_FIN;
            end
          end
        end
        ST_FIN: begin
          done_o <= 1'b1;
          st <= ST_IDLE;
          // Final address updates override any value loaded into the same register
          if (mask != 16'h0000 || mm_predec || mm_postinc) begin
            if (mm_predec) begin
              rf[{1'b1, areg}] <= addr + mm_len; // RQ18
            end else if (mm_postinc) begin
              rf[{1'b1, areg}] <= addr; // RQ21
            end
          end
          if (inc_src) begin
            rf[{1'b1, sreg}] <= rf[{1'b1, sreg}] + LINE_STEP; // RQ9
          end
          if (inc_dst) begin
            rf[{1'b1, dreg}] <= rf[{1'b1, dreg}] + LINE_STEP; // RQ9
          end
          mm_predec <= 1'b0;
          mm_postinc <= 1'b0;
          inc_src <= 1'b0;
          inc_dst <= 1'b0;
          mask <= 16'h0000;
        end
        default: begin
          st <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // smiu_core

// >>> src/smiu_pkg.sv
// Shared constants and carriers for the special move instruction unit.
// Assumes one 20 MHz core clock and a 32-bit memory bus with valid/ack.
package smiu_pkg;
  // Instruction issue carrier: opcode word, extension words, computed address
  typedef struct packed {
    logic [15:0] opword;
    logic [15:0] ext1;
    logic [15:0] ext2;
    logic [31:0] ea_addr;
  } smiu_issue_s;
  // Memory request carrier
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic we;
    logic word;
    logic burst;
  } smiu_mem_s;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FLAG = 3'b001,
    ST_SRRD = 3'b010,
    ST_SRWR = 3'b011,
    ST_LRD = 3'b100,
    ST_LWR = 3'b101,
    ST_MM = 3'b110,
    ST_FIN = 3'b111
  } smiu_state_e;
  // Opcode patterns
  localparam logic [9:0] OP_FLAG_LOAD = 10'h113;
  localparam logic [9:0] OP_STATUS_STORE = 10'h103;
  localparam logic [12:0] OP_LINE_PI = 13'h1EC4;
  localparam logic [10:0] OP_LINE_ABS = 11'h7B0;
  localparam logic [4:0] OP_MM_HI = 5'h09;
  localparam logic [2:0] OP_MM_MID = 3'h1;
  localparam logic [15:0] LINE_EXT_MASK = 16'h8FFF;
  localparam logic [15:0] LINE_EXT_VAL = 16'h8000;
  // Legal addressing modes: one bit per mode, and per register for mode 7
  localparam logic [7:0] EA_DATA_MODES = 8'hFD;
  localparam logic [7:0] EA_DATA_ABS = 8'h1F;
  localparam logic [7:0] EA_DALT_MODES = 8'hFD;
  localparam logic [7:0] EA_DALT_ABS = 8'h03;
  localparam logic [7:0] EA_MMST_MODES = 8'hF4;
  localparam logic [7:0] EA_MMST_ABS = 8'h03;
  localparam logic [7:0] EA_MMLD_MODES = 8'hEC;
  localparam logic [7:0] EA_MMLD_ABS = 8'h0F;
  localparam logic [2:0] MODE_DREG = 3'h0;
  localparam logic [2:0] MODE_POSTINC = 3'h3;
  localparam logic [2:0] MODE_PREDEC = 3'h4;
  localparam logic [2:0] MODE_EXT = 3'h7;
  localparam logic [2:0] REG_IMM = 3'h4;
  // Status register implemented bits and reset value
  localparam logic [15:0] SR_IMPL_MASK = 16'hA71F;
  localparam logic [15:0] SR_RESET = 16'h2700;
  localparam logic [31:0] LINE_STEP = 32'h00000010;
  localparam logic [31:0] LEN_WORD = 32'h00000002;
  localparam logic [31:0] LEN_LONG = 32'h00000004;
  // Wishbone word indices (byte address = index * 4)
  localparam logic [4:0] IDX_SR = 5'h10;
  localparam logic [4:0] IDX_CTRL = 5'h11;
  localparam logic [4:0] IDX_STAT = 5'h12;
  localparam logic CTRL_RESET = 1'b0;
endpackage

// >>> verif/smiu_core_assertions.sv
// Checker bound to smiu_core.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module smiu_core_assertions (
  input logic clk_i,
  input logic rst_i,
  input logic issue_valid_i,
  input smiu_pkg::smiu_issue_s issue_i,
  input logic issue_ready_o,
  input logic illegal_o,
  input logic done_o,
  input logic mem_valid_o,
  input smiu_pkg::smiu_mem_s mem_req_o,
  input logic mem_ack_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_ack_o
);
  import smiu_pkg::*;
  logic [1:0] bcnt;
  logic [31:0] blast;
  logic blwe;
  // Decode seen at the issue port
  wire [15:0] ow = issue_i.opword;
  wire tk = issue_valid_i && issue_ready_o;
  wire [2:0] md = ow[5:3];
  wire [2:0] rg = ow[2:0];
  wire fl = tk && ow[15:6] == OP_FLAG_LOAD;
  wire ss = tk && ow[15:6] == OP_STATUS_STORE;
  wire mm = tk && ow[15:11] == OP_MM_HI && ow[9:7] == OP_MM_MID;
  wire ln = tk && ow[15:3] == OP_LINE_PI && (issue_i.ext1 & LINE_EXT_MASK) == LINE_EXT_VAL;
  wire ssm = ss && (md == 3'h2 || (md == MODE_EXT && rg < 3'h2));
  // Burst beat count, wraps per line
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bcnt <= 2'h0;
    end else if (mem_valid_o && mem_ack_i && mem_req_o.burst) begin
      bcnt <= bcnt + 2'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (mem_valid_o && mem_ack_i) begin
      blast <= mem_req_o.addr;
      blwe <= mem_req_o.we;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_word_rd;
    mem_valid_o && mem_req_o.word && !mem_req_o.we
      && mem_req_o.addr == $past(issue_i.ea_addr);
  endsequence
  sequence s_next_beat;
    mem_req_o.we == blwe && mem_req_o.addr[31:4] == blast[31:4]
      && mem_req_o.addr[3:2] == blast[3:2] + 2'h1;
  endsequence
  property p_wb_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("wb ack timing");
  property p_mem_hold;
    mem_valid_o && !mem_ack_i |=> mem_valid_o && $stable(mem_req_o);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("mem request moved");
  property p_fl_dn;
    fl && md == MODE_DREG |=> done_o;
  endproperty
  a_fl_dn: assert property (p_fl_dn) else $error("flag load late");
  property p_fl_an;
    fl && md == 3'h1 |=> illegal_o && !mem_valid_o;
  endproperty
  a_fl_an: assert property (p_fl_an) else $error("flag load addr reg");
  property p_fl_mem;
    fl && md == 3'h2 |=> s_word_rd;
  endproperty
  a_fl_mem: assert property (p_fl_mem) else $error("flag fetch size");
  property p_ss_rd;
    ssm |=> s_word_rd;
  endproperty
  a_ss_rd: assert property (p_ss_rd) else $error("store skipped read");
  property p_ss_ill;
    ss && (md == 3'h1 || (md == MODE_EXT && rg > 3'h1)) |=> illegal_o;
  endproperty
  a_ss_ill: assert property (p_ss_ill) else $error("bad store target");
  property p_quiet;
    illegal_o |-> !mem_valid_o && !done_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("refused op moved");
  property p_mm_ill;
    mm && (ow[10] ? md == MODE_PREDEC : md == MODE_POSTINC) |=> illegal_o;
  endproperty
  a_mm_ill: assert property (p_mm_ill) else $error("bad multi mode");
  property p_ln_rd;
    ln |=> mem_valid_o && mem_req_o.burst && !mem_req_o.we && mem_req_o.addr[1:0] == 2'h0;
  endproperty
  a_ln_rd: assert property (p_ln_rd) else $error("line read missing");
  property p_beat;
    mem_valid_o && mem_req_o.burst && bcnt != 2'h0 |-> s_next_beat;
  endproperty
  a_beat: assert property (p_beat) else $error("beat left line");
endmodule // smiu_core_assertions
bind smiu_core smiu_core_assertions smiu_core_assertions_inst (.clk_i, .rst_i, .issue_valid_i,
  .issue_i, .issue_ready_o, .illegal_o, .done_o, .mem_valid_o, .mem_req_o, .mem_ack_i,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o);

// >>> verif/smiu_mem_model.sv
// Memory on the unit's far side; read data is a pattern of the address.
// Assumes the core clock; answers after 0 or 1 idle cycle.
`timescale 1ns/1ps
module smiu_mem_model (
  input logic clk_i,
  input logic rst_i,
  input logic mem_valid_i,
  input logic [31:0] mem_addr_i,
  output logic mem_ack_o,
  output logic [31:0] mem_rdata_o
);
  logic waited;
  // Low half sign tracks the address, for sign extension
  function automatic logic [31:0] pat(input logic [31:0] a);
    return {a[15:0] ^ 16'h5A5A, ~a[15:0]};
  endfunction
  // Idle data scrambled so stale data never matches
  always_ff @(posedge clk_i) begin
    if (rst_i || mem_ack_o || !mem_valid_i) begin
      mem_ack_o <= 1'b0;
      waited <= 1'b0;
      mem_rdata_o <= $urandom;
    end else if (waited || $urandom_range(1) == 1) begin
      mem_ack_o <= 1'b1;
      mem_rdata_o <= pat(mem_addr_i);
    end else begin
      waited <= 1'b1;
      mem_rdata_o <= $urandom;
    end
  end
endmodule // smiu_mem_model

// >>> verif/smiu_core_tb.sv
// Self-checking bench for smiu_core: drives issue and Wishbone ports.
// Assumes smiu_mem_model on the far side.
`timescale 1ns/1ps
module smiu_core_tb;
  import smiu_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic iv = 1'b0;
  smiu_issue_s iss = '0;
  logic rdy, ill, done, mv, ack, wack;
  smiu_mem_s mq, me;
  logic [31:0] rd, wdo, ab;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, leg = 1'b0;
  logic [31:0] adr = '0, wdi = '0;
  logic [31:0] rf [16];
  logic [15:0] sr, e1;
  smiu_mem_s eq [$];
  logic [31:0] wq [$];
  int bad_count = 0, num_checks = 0, cyc_n = 0;
  initial forever #25 clk_i = ~clk_i;
  smiu_core smiu_core_inst (.clk_i, .rst_i, .issue_valid_i(iv), .issue_i(iss),
    .issue_ready_o(rdy), .illegal_o(ill), .done_o(done), .mem_valid_o(mv), .mem_req_o(mq),
    .mem_ack_i(ack), .mem_rdata_i(rd), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdi), .wb_sel_i(4'hF), .wb_dat_o(wdo), .wb_ack_o(wack));
  smiu_mem_model smiu_mem_model_inst (.clk_i, .rst_i, .mem_valid_i(mv),
    .mem_addr_i(mq.addr), .mem_ack_o(ack), .mem_rdata_o(rd));
  task automatic chk(input string n, input logic [31:0] e, s);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Watcher: each answer against the oldest note
  always @(posedge clk_i) begin
    cyc_n++;
    if (mv && ack) begin
      me = eq.pop_front();
      chk("mem_addr", me.addr, mq.addr);
      chk("mem_kind", {me.we, me.word, me.burst}, {mq.we, mq.word, mq.burst});
      if (me.we) chk("mem_wdata", me.wdata, mq.wdata & (me.word ? 32'hFFFF : '1));
    end
    if (wack && !we) chk("wb_rdata", wq.pop_front(), wdo);
    if (cyc_n > 20000) begin
      bad_count++;
      final_report();
    end
  end
  // Classic Wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [31:0] a, d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdi <= d;
    do @(posedge clk_i); while (wack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
    wq.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic setr(input int i, input logic [31:0] v);
    rf[i] = v;
    wb(1'b1, 32'(i * 4), v);
  endtask
  task automatic ex(input logic [31:0] a, d, input logic w, wd, b);
    eq.push_back('{a, d, w, wd, b});
  endtask
  // Issue one instruction, wait for done or refusal
  task automatic run(input logic [15:0] op, x1, x2, input logic [31:0] ea, input logic bad);
    @(posedge clk_i);
    iv <= 1'b1;
    iss <= '{op, x1, x2, ea};
    do @(posedge clk_i); while (rdy !== 1'b1);
    iv <= 1'b0;
    do @(posedge clk_i); while (done !== 1'b1 && ill !== 1'b1);
    chk("refused", {31'h0, bad}, {31'h0, ill});
    chk("mem_left", 32'h0, eq.size());
  endtask
  task automatic line(input logic [31:0] s, d);
    logic [1:0] j;
    for (int k = 0; k < 4; k++) ex({s[31:4], s[3:2] + 2'(k), 2'h0}, 0, 0, 0, 1);
    for (int k = 0; k < 4; k++) begin
      j = d[3:2] + 2'(k);
      ex({d[31:4], j, 2'h0}, smiu_mem_model_inst.pat({s[31:4], j, 2'h0}), 1, 0, 1);
    end
  endtask
  // Multi move: note accesses and register results, then issue
  task automatic mm(input logic dr, sz, input logic [2:0] md, input logic [2:0] r,
      input logic [15:0] m, input logic [31:0] ea);
    logic [31:0] a, n, v;
    int x;
    n = sz ? LEN_LONG : LEN_WORD;
    a = md == MODE_PREDEC ? rf[8 + r] - n : (md == MODE_POSTINC ? rf[8 + r] : ea);
    for (int k = 0; k < 16; k++) if (m[k]) begin
      x = md == MODE_PREDEC ? 15 - k : k;
      v = smiu_mem_model_inst.pat(a);
      if (dr) ex(a, 0, 0, !sz, 0);
      else ex(a, (x == 8 + r && md == MODE_PREDEC && !leg ? rf[x] - n : rf[x]) & (sz ? '1 :
        32'hFFFF), 1, !sz, 0);
      if (dr) rf[x] = sz ? v : {{16{v[15]}}, v[15:0]};
      a = md == MODE_PREDEC ? a - n : a + n;
    end
    if (md == MODE_PREDEC) rf[8 + r] = a + n;
    if (md == MODE_POSTINC) rf[8 + r] = a;
    run({OP_MM_HI, dr, OP_MM_MID, sz, md, r}, m, 16'h0, ea, 1'b0);
  endtask
  task automatic regs();
    for (int i = 0; i < 16; i++) rdchk(32'(i * 4), rf[i]);
  endtask
  initial begin
    ab = $urandom(32'h9B59CBDC);
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rf[i]) rf[i] = 32'h0;
    regs();
    rdchk(32'h40, {16'h0, SR_RESET});
    rdchk(32'h44, 32'h0);
    rdchk(32'h80, 32'h0);
    wb(1'b1, 32'h40, 32'h0000FFFF);
    sr = SR_IMPL_MASK;
    rdchk(32'h40, {16'h0, sr});
    for (int i = 0; i < 16; i++) setr(i, $urandom);
    $display("test regs done");
    run({OP_FLAG_LOAD, MODE_DREG, 3'h3}, 16'h0, 16'h0, 32'h0, 1'b0);
    sr[4:0] = rf[3][4:0];
    rdchk(32'h40, {16'h0, sr});
    e1 = 16'($urandom);
    run({OP_FLAG_LOAD, MODE_EXT, REG_IMM}, e1, 16'h0, 32'h0, 1'b0);
    sr[4:0] = e1[4:0];
    rdchk(32'h40, {16'h0, sr});
    ex(32'h1234, 0, 0, 1, 0);
    run({OP_FLAG_LOAD, 3'h2, 3'h0}, 16'h0, 16'h0, 32'h1234, 1'b0);
    sr[4:0] = smiu_mem_model_inst.pat(32'h1234);
    run({OP_FLAG_LOAD, 3'h1, 3'h0}, 16'h0, 16'h0, 32'h0, 1'b1);
    run({OP_FLAG_LOAD, MODE_EXT, 3'h5}, 16'h0, 16'h0, 32'h0, 1'b1);
    rdchk(32'h48, 32'h2);
    wb(1'b1, 32'h48, 32'h2);
    rdchk(32'h48, 32'h0);
    rdchk(32'h40, {16'h0, sr});
    $display("test flag load done");
    setr(2, 32'h0);
    run({OP_STATUS_STORE, MODE_DREG, 3'h2}, 16'h0, 16'h0, 32'h0, 1'b0);
    rf[2] = {16'h0, sr};
    ex(32'h2222, 0, 0, 1, 0);
    ex(32'h2222, {16'h0, sr}, 1, 1, 0);
    run({OP_STATUS_STORE, 3'h2, 3'h1}, 16'h0, 16'h0, 32'h2222, 1'b0);
    run({OP_STATUS_STORE, 3'h1, 3'h1}, 16'h0, 16'h0, 32'h0, 1'b1);
    for (int r = 2; r < 5; r++) run({OP_STATUS_STORE, MODE_EXT, 3'(r)}, 0, 0, 0, 1);
    rdchk(32'h40, {16'h0, sr});
    $display("test store done");
    setr(9, 32'h00014008);
    setr(10, 32'h000FE804);
    line(rf[9], rf[10]);
    run({OP_LINE_PI, 3'h1}, {1'b1, 3'h2, 12'h0}, 16'h0, 32'h0, 1'b0);
    rf[9] += LINE_STEP;
    rf[10] += LINE_STEP;
    run({OP_LINE_PI, 3'h1}, 16'h8001, 16'h0, 32'h0, 1'b1);
    for (int op = 0; op < 4; op++) begin
      ab = $urandom;
      line(op[0] ? ab : rf[11], op[0] ? rf[11] : ab);
      run({OP_LINE_ABS, 2'(op), 3'h3}, ab[31:16], ab[15:0], 32'h0, 1'b0);
      if (!op[1]) rf[11] += LINE_STEP;
    end
    regs();
    $display("test line done");
    mm(0, 0, 3'h2, 3'h0, 16'($urandom), 32'h5000);
    mm(1, 1, MODE_EXT, 3'h1, 16'($urandom), 32'h6000);
    mm(1, 0, 3'h5, 3'h2, 16'hFFFF, 32'h7000);
    setr(13, 32'h8000);
    mm(0, 1, MODE_PREDEC, 3'h5, 16'h8F04, 32'h0);
    wb(1'b1, 32'h44, 32'h1);
    leg = 1'b1;
    mm(0, 0, MODE_PREDEC, 3'h5, 16'h00FF, 32'h0);
    setr(14, 32'hA000);
    mm(1, 0, MODE_POSTINC, 3'h6, 16'h4081, 32'h0);
    run({OP_MM_HI, 1'b1, OP_MM_MID, 1'b0, MODE_PREDEC, 3'h0}, '1, 0, 0, 1);
    run({OP_MM_HI, 1'b0, OP_MM_MID, 1'b1, MODE_POSTINC, 3'h0}, '1, 0, 0, 1);
    run({OP_MM_HI, 1'b0, OP_MM_MID, 1'b1, MODE_DREG, 3'h0}, '1, 0, 0, 1);
    regs();
    $display("test multi done");
    final_report();
  end
endmodule // smiu_core_tb
